// [hdl/rsf_pkg.sv]
// Constants, field layouts and carrier types for the science frame generator.
// Assumes one core clock; every slower rate is an enable pulse derived from it.
// Function
// - Start streaming on first second pulse after power-on
// - One fixed-length frame every 1.024 seconds
// - Frames run back to back until power-off
// - Converter samples taken at ten megasamples per second
// - Command-loaded selector picks converter or seven patterns
// - Frames carry I/Q pairs and radiometry values
// - Frames carry contiguity-checkable time tags
// - Multi-byte values interleaved across the frame
// - Reference clock drives logic; second pulse frames data
// - Frames leave on dedicated stream port only
// - First frame byte is identifier B7
// - Status byte holds selector in bits six-four
// - 24-bit tags, MSB first, every 102.4 ms, cleared only by reset
// - 40-bit squared-sample sums, MSB first, cleared per frame
package rsf_pkg;

    // Clock and sample rates
    localparam int CLK_MHZ = 125;
    localparam int SAMPLE_RATE_MHZ = 10;
    localparam logic [7:0] TICK_STEP = 8'h0A;
    localparam logic [7:0] TICK_WRAP = 8'h7D;

    // Frame timing: tag period in microseconds, sample counts derived from it
    localparam int TAG_PERIOD_US = 102400;
    localparam int SAMPLES_PER_TAG = TAG_PERIOD_US * SAMPLE_RATE_MHZ;
    localparam int PAIRS_PER_TAG = 125;
    localparam int SAMPLES_PER_PAIR = SAMPLES_PER_TAG / PAIRS_PER_TAG;
    localparam int TAGS_PER_FRAME = 10;
    localparam int AUX_BYTES = 8;

    // Frame header fields
    localparam logic [7:0] FRAME_ID = 8'hB7;
    localparam int STATUS_SEL_LSB = 4;

    // Source selector codes
    localparam logic [2:0] SEL_ADC = 3'h0;
    localparam logic [2:0] SEL_IMPULSE = 3'h1;
    localparam logic [2:0] SEL_SQ_LOW = 3'h2;
    localparam logic [2:0] SEL_SQ_MID = 3'h3;
    localparam logic [2:0] SEL_PRN_UNIT = 3'h4;
    localparam logic [2:0] SEL_PRN_FULL = 3'h5;
    localparam logic [2:0] SEL_SQ_HIGH = 3'h6;
    localparam logic [2:0] SEL_ZERO = 3'h7;

    // Test pattern amplitudes and square wave phase bits
    localparam logic signed [11:0] IMPULSE_LEVEL = 12'h080;
    localparam int IMPULSE_SAMPLES = 2;
    localparam logic signed [11:0] SQUARE_LEVEL = 12'h100;
    localparam int SQ_LOW_BIT = 13;
    localparam int SQ_MID_BIT = 8;
    localparam int SQ_HIGH_BIT = 6;
    localparam logic [15:0] LFSR_SEED = 16'hACE1;

    // Widths and buffer shape
    localparam int SAMPLE_W = 12;
    localparam int SUM_W = 24;
    localparam int RAD_W = 40;
    localparam int TAG_W = 24;
    localparam int FIFO_W = 9;
    localparam int FIFO_DEPTH = 8;

    // One I/Q pair as produced by the decimator
    typedef struct packed {
        logic [15:0] i;
        logic [15:0] q;
    } rsf_iq_t;

    // Per-tag auxiliary values
    typedef struct packed {
        logic [RAD_W-1:0] rad;
        logic [TAG_W-1:0] tag;
    } rsf_aux_t;

    // Byte on its way out, with a start-of-frame marker
    typedef struct packed {
        logic sof;
        logic [7:0] data;
    } rsf_byte_t;

endpackage

// [hdl/rsf_fifo.sv]
// Small synchronous FIFO with valid/ready on both sides.
// Assumes both sides share the one clock and reset.
`timescale 1ns/1ps
module rsf_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    // Storage and pointers with a wrap bit
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    wire do_write;
    wire do_read;
    wire is_empty;
    wire is_full;

    // Full when indices match and wrap bits differ
    assign is_empty = (wr_ptr == rd_ptr);
    assign is_full = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
    assign in_ready = !is_full;
    assign out_valid = !is_empty;
    assign do_write = in_valid && !is_full;
    assign do_read = out_ready && !is_empty;
    assign out_data = mem[rd_ptr[AW-1:0]];

    // Pointer update
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            if (do_write)
                wr_ptr <= wr_ptr + 1'b1;
            if (do_read)
                rd_ptr <= rd_ptr + 1'b1;
        end
    end

    // One entry per generate slot; each slot loads only when addressed
    for (genvar e = 0; e < DEPTH; e++)
    begin : g_entry
        always_ff @(posedge core_clk or negedge nrst)
        begin
            if (!nrst)
                mem[e] <= '0;
            else if (do_write && (wr_ptr[AW-1:0] == AW'(e)))
                mem[e] <= in_data;
        end
    end

endmodule // rsf_fifo

// [hdl/rsf_frame_gen.sv]
// Science frame generator: sample selection, decimation, radiometry, framing.
// Assumes uplink logic on the same clock gives command strobes, the ADC is
// converted on adc_convert, and the second pulse arrives asynchronously.
`timescale 1ns/1ps
module rsf_frame_gen #(
    parameter int SAMPLES_PER_PAIR = rsf_pkg::SAMPLES_PER_PAIR
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic power_on_cmd,
    input wire logic select_load,
    input wire logic [2:0] select_value,
    input wire logic second_pulse,
    output logic adc_convert,
    input wire logic [11:0] adc_data,
    output logic [7:0] frame_data,
    output logic frame_sof,
    output logic frame_valid,
    input wire logic frame_ready,
    output logic running,
    output logic overrun
);
    // Serializer states
    typedef enum logic [2:0] {
        SER_IDLE, SER_ID, SER_STATUS, SER_I_HI, SER_I_LO, SER_Q_HI, SER_Q_LO, SER_AUX
    } rsf_ser_t;

    localparam logic [12:0] LAST_SAMPLE = 13'(SAMPLES_PER_PAIR - 1);
    localparam logic [6:0] LAST_PAIR = 7'(rsf_pkg::PAIRS_PER_TAG - 1);
    localparam logic [3:0] LAST_SEG = 4'(rsf_pkg::TAGS_PER_FRAME - 1);

    // Second pulse synchroniser and filtered level
    logic pps_s1;
    logic pps_s2;
    logic pps_s3;
    logic pps_level;
    wire pps_rise;

    // Start control
    logic armed;
    logic [2:0] source_select;
    logic [2:0] frame_sel;

    // Sample tick divider and ADC capture
    logic [7:0] tick_acc;
    logic tick;
    logic signed [11:0] adc_reg;
    wire [7:0] tick_sum;

    // Frame position counters
    logic [12:0] samp_cnt;
    logic [6:0] pair_cnt;
    logic [3:0] seg_cnt;
    logic [13:0] wave_phase;
    logic [15:0] lfsr;

    // Accumulators and latched values
    logic signed [23:0] i_sum;
    logic signed [23:0] q_sum;
    logic [39:0] rad_acc;
    logic [23:0] tag_cnt;
    rsf_pkg::rsf_aux_t aux;
    rsf_pkg::rsf_iq_t pair_hold;
    logic [2:0] aux_idx;
    logic aux_due;

    // Serializer state and pending requests
    rsf_ser_t ser_state;
    rsf_ser_t next_ser_state;
    logic pair_pend;
    logic hdr_pend;

    // Synchroniser: first stage read only by the second
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pps_s1 <= 1'b0;
            pps_s2 <= 1'b0;
            pps_s3 <= 1'b0;
            pps_level <= 1'b0;
        end
        else
        begin
            pps_s1 <= second_pulse;
            pps_s2 <= pps_s1;
            pps_s3 <= pps_s2;
            if (pps_s2 == pps_s3)
                pps_level <= pps_s3;
        end
    end

    // Rising edge only once two later stages agree
    assign pps_rise = (pps_s2 == pps_s3) && pps_s3 && !pps_level;

    // Arm on power-on; run from next second pulse until reset
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            armed <= 1'b0;
            running <= 1'b0;
        end
        else
        begin
            if (power_on_cmd)
                armed <= 1'b1;
            if (armed && pps_rise && !running)
                running <= 1'b1;
        end
    end

    // Selector register loaded by command strobe
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            source_select <= rsf_pkg::SEL_ADC;
        else if (select_load)
            source_select <= select_value;
    end

    // Fractional divider: ten ticks per 125 clocks, evenly spread
    assign tick_sum = tick_acc + rsf_pkg::TICK_STEP;
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            tick_acc <= 8'h00;
            tick <= 1'b0;
        end
        else if (tick_sum >= rsf_pkg::TICK_WRAP)
        begin
            tick_acc <= tick_sum - rsf_pkg::TICK_WRAP;
            tick <= 1'b1;
        end
        else
        begin
            tick_acc <= tick_sum;
            tick <= 1'b0;
        end
    end
    assign adc_convert = tick;

    // Converter word is valid on its tick; held for the whole sample
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            adc_reg <= 12'sh000;
        else if (tick)
            adc_reg <= adc_data;
    end

    // Frame position decode
    wire step = running && tick;
    wire boundary = (samp_cnt == 13'h0000) && (pair_cnt == 7'h00);
    wire frame_start = boundary && (seg_cnt == 4'h0);
    wire pair_done = samp_cnt == LAST_SAMPLE;
    // New frame uses the freshly loaded selector so status and data agree
    wire [2:0] eff_sel = frame_start ? source_select : frame_sel;

    // Test pattern generation
    wire impulse_on = frame_start || ((seg_cnt == 4'h0) && (pair_cnt == 7'h00)
                      && (samp_cnt < 13'(rsf_pkg::IMPULSE_SAMPLES)));
    wire signed [11:0] sq_low = wave_phase[rsf_pkg::SQ_LOW_BIT] ? -rsf_pkg::SQUARE_LEVEL
                                : rsf_pkg::SQUARE_LEVEL;
    wire signed [11:0] sq_mid = wave_phase[rsf_pkg::SQ_MID_BIT] ? -rsf_pkg::SQUARE_LEVEL
                                : rsf_pkg::SQUARE_LEVEL;
    wire signed [11:0] sq_high = wave_phase[rsf_pkg::SQ_HIGH_BIT] ? -rsf_pkg::SQUARE_LEVEL
                                 : rsf_pkg::SQUARE_LEVEL;
    wire signed [11:0] prn_unit = lfsr[0] ? 12'shFFF : 12'sh001;
    wire signed [11:0] prn_full = lfsr[11:0];
    logic signed [11:0] sample;

    // Source selection; code zero passes converter samples
    always_comb
    begin
        case (eff_sel)
            rsf_pkg::SEL_ADC: sample = adc_reg;
            rsf_pkg::SEL_IMPULSE: sample = impulse_on ? rsf_pkg::IMPULSE_LEVEL : 12'sh000;
            rsf_pkg::SEL_SQ_LOW: sample = sq_low;
            rsf_pkg::SEL_SQ_MID: sample = sq_mid;
            rsf_pkg::SEL_PRN_UNIT: sample = prn_unit;
            rsf_pkg::SEL_PRN_FULL: sample = prn_full;
            rsf_pkg::SEL_SQ_HIGH: sample = sq_high;
            default: sample = 12'sh000;
        endcase
    end

    // Quarter-rate mixer to baseband, then boxcar decimation per pair
    wire signed [23:0] s_ext = 24'(sample);
    wire signed [23:0] i_term = samp_cnt[0] ? 24'sh00_0000 : (samp_cnt[1] ? -s_ext : s_ext);
    wire signed [23:0] q_term = !samp_cnt[0] ? 24'sh00_0000 : (samp_cnt[1] ? s_ext : -s_ext);
    wire signed [23:0] next_i_sum = (samp_cnt == 13'h0000 ? 24'sh00_0000 : i_sum) + i_term;
    wire signed [23:0] next_q_sum = (samp_cnt == 13'h0000 ? 24'sh00_0000 : q_sum) + q_term;

    // Power of the sample; accumulator restarts at every frame start
    wire signed [23:0] sq_signed = s_ext * s_ext;
    wire [39:0] sq_ext = {16'h0000, sq_signed[23:0]};
    wire [39:0] next_rad_acc = (frame_start ? 40'h00_0000_0000 : rad_acc) + sq_ext;

    // Counter advance for a running sample
    wire [12:0] next_samp = pair_done ? 13'h0000 : samp_cnt + 13'h0001;
    wire seg_end = pair_done && (pair_cnt == LAST_PAIR);
    wire [6:0] next_pair = seg_end ? 7'h00 : (pair_done ? pair_cnt + 7'h01 : pair_cnt);
    wire [3:0] next_seg = !seg_end ? seg_cnt : (seg_cnt == LAST_SEG ? 4'h0 : seg_cnt + 4'h1);
    wire lfsr_fb = lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10];

    // Position counters: frames follow back to back with no gap
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            samp_cnt <= 13'h0000;
            pair_cnt <= 7'h00;
            seg_cnt <= 4'h0;
            wave_phase <= 14'h0000;
            lfsr <= rsf_pkg::LFSR_SEED;
        end
        else if (step)
        begin
            samp_cnt <= next_samp;
            pair_cnt <= next_pair;
            seg_cnt <= next_seg;
            wave_phase <= wave_phase + 14'h0001;
            lfsr <= {lfsr[14:0], lfsr_fb};
        end
    end

    // Decimator sums and radiometry accumulator
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            i_sum <= 24'sh00_0000;
            q_sum <= 24'sh00_0000;
            rad_acc <= 40'h00_0000_0000;
        end
        else if (step)
        begin
            i_sum <= next_i_sum;
            q_sum <= next_q_sum;
            rad_acc <= next_rad_acc;
        end
    end

    // Tag boundary: snapshot radiometry and tag, bump the tag
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            aux <= '0;
            tag_cnt <= 24'h00_0000;
            frame_sel <= rsf_pkg::SEL_ADC;
        end
        else if (step && boundary)
        begin
            // Snapshot precedes this sample, so slot 0 holds last full frame
            aux.rad <= rad_acc;
            aux.tag <= tag_cnt;
            tag_cnt <= tag_cnt + 24'h00_0001;
            if (frame_start)
                frame_sel <= source_select;
        end
    end

    // Aux byte order per pair slot: rad and tag bytes alternate for six slots, then the last two rad bytes, MSB first
    wire [63:0] aux_bytes = {aux.rad[39:32], aux.tag[23:16], aux.rad[31:24], aux.tag[15:8],
                             aux.rad[23:16], aux.tag[7:0], aux.rad[15:8], aux.rad[7:0]};
    wire [7:0] aux_byte = aux_bytes[6'(63 - 8 * aux_idx) -: 8];
    wire [7:0] status_byte = 8'({frame_sel, 4'h0});

    // Serializer handshake into the buffer
    wire fifo_in_ready;
    wire ser_busy = ser_state != SER_IDLE;
    wire emit = ser_busy && fifo_in_ready;
    wire take_pair = !ser_busy && pair_pend && !hdr_pend;
    wire take_hdr = !ser_busy && hdr_pend;
    // Aux byte follows only pairs 0..7 of a segment
    wire aux_next = aux_due;
    rsf_pkg::rsf_byte_t ser_byte;

    // Byte selection by state
    always_comb
    begin
        ser_byte.sof = 1'b0;
        case (ser_state)
            SER_ID:
            begin
                ser_byte.sof = 1'b1;
                ser_byte.data = rsf_pkg::FRAME_ID;
            end
            SER_STATUS: ser_byte.data = status_byte;
            SER_I_HI: ser_byte.data = pair_hold.i[15:8];
            SER_I_LO: ser_byte.data = pair_hold.i[7:0];
            SER_Q_HI: ser_byte.data = pair_hold.q[15:8];
            SER_Q_LO: ser_byte.data = pair_hold.q[7:0];
            SER_AUX: ser_byte.data = aux_byte;
            default: ser_byte.data = 8'h00;
        endcase
    end

    // Next state; header outranks a waiting pair since it leads the frame
    always_comb
    begin
        next_ser_state = ser_state;
        case (ser_state)
            SER_IDLE:
            begin
                if (take_hdr)
                    next_ser_state = SER_ID;
                else if (take_pair)
                    next_ser_state = SER_I_HI;
            end
            SER_ID: next_ser_state = emit ? SER_STATUS : SER_ID;
            SER_STATUS: next_ser_state = emit ? SER_IDLE : SER_STATUS;
            SER_I_HI: next_ser_state = emit ? SER_I_LO : SER_I_HI;
            SER_I_LO: next_ser_state = emit ? SER_Q_HI : SER_I_LO;
            SER_Q_HI: next_ser_state = emit ? SER_Q_LO : SER_Q_HI;
            SER_Q_LO:
            begin
                if (emit)
                    next_ser_state = aux_next ? SER_AUX : SER_IDLE;
            end
            SER_AUX: next_ser_state = emit ? SER_IDLE : SER_AUX;
            default: next_ser_state = SER_IDLE;
        endcase
    end

    // Serializer state register
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            ser_state <= SER_IDLE;
        else
            ser_state <= next_ser_state;
    end

    // Pending requests: a new request in the take cycle still wins
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pair_pend <= 1'b0;
            hdr_pend <= 1'b0;
            overrun <= 1'b0;
        end
        else
        begin
            pair_pend <= (step && pair_done) || (pair_pend && !take_pair);
            hdr_pend <= (step && frame_start) || (hdr_pend && !take_hdr);
            // Sticky: a pair finished before the previous one left
            if (step && pair_done && (pair_pend || ser_busy))
                overrun <= 1'b1;
        end
    end

    // Pair hold: captured when the last sample of the pair lands
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pair_hold <= '0;
            aux_idx <= 3'h0;
            aux_due <= 1'b0;
        end
        else if (step && pair_done)
        begin
            pair_hold.i <= next_i_sum[23:8];
            pair_hold.q <= next_q_sum[23:8];
            aux_idx <= pair_cnt[2:0];
            aux_due <= pair_cnt < 7'(rsf_pkg::AUX_BYTES);
        end
    end

    // Output buffer on the dedicated stream port
    rsf_pkg::rsf_byte_t out_word;
    wire out_valid;
    rsf_fifo #(
        .WIDTH(rsf_pkg::FIFO_W),
        .DEPTH(rsf_pkg::FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .nrst(nrst),
        .in_valid(emit),
        .in_ready(fifo_in_ready),
        .in_data(ser_byte),
        .out_valid(out_valid),
        .out_ready(frame_ready),
        .out_data(out_word)
    );

    assign frame_data = out_word.data;
    assign frame_sof = out_word.sof;
    assign frame_valid = out_valid;

endmodule // rsf_frame_gen

// [tb/rsf_frame_gen_properties.sv]
// Port-level checks of the science frame generator.
// Assumes one clock domain; bound to every rsf_frame_gen instance.
`timescale 1ns/1ps
module rsf_frame_gen_chk (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic second_pulse,
    input wire logic adc_convert,
    input wire logic [7:0] frame_data,
    input wire logic frame_sof,
    input wire logic frame_valid,
    input wire logic frame_ready,
    input wire logic running
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // Byte handed over this cycle
    wire taken = frame_valid && frame_ready;
    // Window of 125 clocks opened at a convert pulse
    logic win_on;
    logic [6:0] win_clk;
    logic [3:0] win_cnt;
    // High while the byte after the identifier is pending
    logic after_id;
    wire win_end = win_clk == 7'h7C;
    // Rate window; starts at a pulse so the count is phase-free
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            win_on <= 1'b0;
            win_clk <= 7'h00;
            win_cnt <= 4'h0;
        end
        else if (!win_on)
        begin
            win_on <= adc_convert;
            win_clk <= 7'(adc_convert);
            win_cnt <= 4'(adc_convert);
        end
        else
        begin
            win_clk <= win_end ? 7'h00 : win_clk + 7'h01;
            win_cnt <= win_end ? 4'h0 : win_cnt + 4'(adc_convert);
        end
    end
    // Tracks the status byte slot
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            after_id <= 1'b0;
        else if (taken)
            after_id <= frame_sof;
    end
    AST_ADC_RATE: assert property (win_on && win_end |-> win_cnt + 4'(adc_convert) == 4'hA)
        else $error("convert pulses per 125 clocks not ten");
    AST_ADC_GAP: assert property (adc_convert |=> !adc_convert [*8])
        else $error("convert pulses too close");
    // Pin must have been high for both agreeing sync stages before the start
    AST_RUN_NEEDS_PULSE: assert property ($rose(running) |-> $past(second_pulse, 3) && $past(second_pulse, 4))
        else $error("running set without a second pulse");
    AST_RUN_STAYS: assert property (running |=> running)
        else $error("running dropped");
    AST_NO_DATA_IDLE: assert property (!running |-> !frame_valid)
        else $error("data offered before start");
    AST_START_SOF: assert property ($rose(running) |-> ##[1:60] (frame_valid && frame_sof))
        else $error("no frame start after running set");
    AST_SOF_ID: assert property (frame_valid && frame_sof |-> frame_data == rsf_pkg::FRAME_ID)
        else $error("frame start byte is not the identifier");
    AST_STATUS_ZERO: assert property (after_id && frame_valid |-> frame_data[7] == 1'b0
        && frame_data[3:0] == 4'h0)
        else $error("status byte spare bits not zero");
    AST_HOLD: assert property (frame_valid && !frame_ready |=> frame_valid
        && $stable(frame_data) && $stable(frame_sof))
        else $error("offered byte changed before taken");
    cover property (taken && frame_sof);
    cover property ($rose(running));
    cover property (frame_valid && !frame_ready);
endmodule // rsf_frame_gen_chk

bind rsf_frame_gen rsf_frame_gen_chk u_rsf_frame_gen_chk (
    .core_clk(core_clk),
    .nrst(nrst),
    .second_pulse(second_pulse),
    .adc_convert(adc_convert),
    .frame_data(frame_data),
    .frame_sof(frame_sof),
    .frame_valid(frame_valid),
    .frame_ready(frame_ready),
    .running(running)
);

// [tb/rsf_sink.sv]
// Model of the instrument interface card taking the byte stream.
// Assumes the generator's clock; stalls at random so the FIFO backs up.
`timescale 1ns/1ps
module rsf_sink #(
    parameter int STALL_PCT = 25
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic frame_valid,
    input wire logic frame_sof,
    input wire logic [7:0] frame_data,
    output logic frame_ready = 1'b0
);
    // Every byte taken, in arrival order
    rsf_pkg::rsf_byte_t got_q[$];
    // Takes on valid and ready, then redraws ready just after the edge
    always @(posedge core_clk)
    begin
        if (nrst && frame_valid && frame_ready)
            got_q.push_back({frame_sof, frame_data});
        #1;
        frame_ready = nrst && ($urandom_range(99) >= STALL_PCT);
    end
endmodule // rsf_sink

// [tb/tb_rsf_frame_gen.sv]
// Self-checking bench: start-up, one frame of layout plus the next frame's first 42 bytes, selector change.
// Assumes the sink model and the bound checker; constant ADC input.
`timescale 1ns/1ps
module tb_rsf_frame_gen;
    localparam int SPP = 4; // Short pairs keep two frames in the run
    localparam int TAG_SAMP = SPP * rsf_pkg::PAIRS_PER_TAG;
    localparam int FRAME_B = 5082;
    localparam int SEG_B = 508;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic power_on_cmd = 1'b0;
    logic select_load = 1'b0;
    logic [2:0] select_value = 3'h0;
    logic second_pulse = 1'b0;
    logic [11:0] adc_data = 12'h000;
    logic adc_convert;
    logic [7:0] frame_data;
    logic frame_sof;
    logic frame_valid;
    logic frame_ready;
    logic running;
    logic overrun;
    int n_fail = 0;
    int samples_checked = 0;
    logic [39:0] v2; // Square of the constant sample
    logic [2:0] sel_q [2]; // Selector expected in each frame
    rsf_frame_gen #(.SAMPLES_PER_PAIR(SPP)) u_rsf_frame_gen (.core_clk(core_clk), .nrst(nrst),
        .power_on_cmd(power_on_cmd), .select_load(select_load), .select_value(select_value),
        .second_pulse(second_pulse), .adc_convert(adc_convert), .adc_data(adc_data),
        .frame_data(frame_data), .frame_sof(frame_sof), .frame_valid(frame_valid),
        .frame_ready(frame_ready), .running(running), .overrun(overrun));
    rsf_sink u_rsf_sink (.core_clk(core_clk), .nrst(nrst), .frame_valid(frame_valid),
        .frame_sof(frame_sof), .frame_data(frame_data), .frame_ready(frame_ready));
    // Free-running core clock
    initial
    begin
        forever #4 core_clk = ~core_clk;
    end
    // Moves to just after a rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
        samples_checked++;
        if (g !== e)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d failures %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Two loads on consecutive edges; the second must win
    task automatic load_two(input logic [2:0] a, input logic [2:0] b);
        select_value = a;
        select_load = 1'b1;
        tick(1);
        select_value = b;
        tick(1);
        select_load = 1'b0;
    endtask
    // Byte n of the stream with its start flag
    function automatic logic [8:0] exp_byte(input int n);
        int f;
        int k;
        int seg;
        int r;
        logic [39:0] rad;
        logic [23:0] tag;
        logic [63:0] aux;
        f = n / FRAME_B;
        k = n % FRAME_B;
        seg = (k - 2) / SEG_B;
        r = (k - 2) % SEG_B;
        rad = (f == 0) ? v2 * seg * TAG_SAMP : ((seg == 0) ? v2 * 10 * TAG_SAMP : 40'h0);
        tag = 24'(f * 10 + seg);
        aux = {rad[39:32], tag[23:16], rad[31:24], tag[15:8], rad[23:16], tag[7:0],
            rad[15:8], rad[7:0]};
        if (k == 0)
            return {1'b1, rsf_pkg::FRAME_ID};
        if (k == 1)
            return {2'b00, sel_q[f], 4'h0};
        if (r >= 5 * rsf_pkg::AUX_BYTES || r % 5 != 4)
            return 9'h000; // Constant input mixes to zero I and Q
        return {1'b0, aux[8 * (7 - r / 5) +: 8]};
    endfunction
    // Main sequence
    initial
    begin
        int w;
        logic signed [11:0] v;
        void'($urandom(70927));
        v = 12'($urandom_range(4095));
        v2 = v * v;
        sel_q[0] = rsf_pkg::SEL_ADC;
        sel_q[1] = rsf_pkg::SEL_ZERO;
        tick(10);
        nrst = 1'b1;
        adc_data = v;
        load_two(3'($urandom_range(7)), rsf_pkg::SEL_ADC);
        second_pulse = 1'b1;
        tick(20);
        second_pulse = 1'b0;
        chk("running unarmed", 40'h0, 40'(running));
        power_on_cmd = 1'b1;
        tick(1);
        power_on_cmd = 1'b0;
        tick(30);
        chk("running no pulse", 40'h0, 40'(running));
        chk("valid idle", 40'h0, 40'(frame_valid));
        second_pulse = 1'b1;
        for (w = 0; w < 20 && running !== 1'b1; w++)
            tick(1);
        chk("running", 40'h1, 40'(running));
        if (running !== 1'b1)
            end_of_test();
        tick(20);
        second_pulse = 1'b0;
        for (w = 0; w < 2000 && u_rsf_sink.got_q.size() < 2; w++)
            tick(1);
        chk("first bytes", 40'h1, 40'(u_rsf_sink.got_q.size() >= 2));
        load_two(3'($urandom_range(7)), rsf_pkg::SEL_ZERO);
        tick(100);
        second_pulse = 1'b1; // Late pulse must not restart framing
        tick(20);
        second_pulse = 1'b0;
        for (w = 0; w < 70000 && u_rsf_sink.got_q.size() < FRAME_B + 42; w++)
            tick(1);
        chk("bytes taken", 40'h1, 40'(u_rsf_sink.got_q.size() >= FRAME_B + 42));
        if (u_rsf_sink.got_q.size() < FRAME_B + 42)
            end_of_test();
        for (int i = 0; i < FRAME_B + 42; i++)
            chk($sformatf("byte %0d", i), 40'(exp_byte(i)), 40'(u_rsf_sink.got_q[i]));
        chk("overrun", 40'h0, 40'(overrun));
        chk("running end", 40'h1, 40'(running));
        end_of_test();
    end
endmodule // tb_rsf_frame_gen
